// ==== reclose_pkg.sv ====
// Shared constants and types for the breaker autoreclose sequencer
package reclose_pkg;

   // Time base: settings count in 0.01 s steps
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 10_000_000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int DIV_W          = 24;

   localparam int TIME_W = 16;
   localparam int SUM_W  = 18;
   localparam int CNT_W  = 3;
   localparam int NUM_T  = 10;

   // Register offsets inside one bank window
   localparam int          BANK_SHIFT = 5;
   localparam logic [4:0]  REG_CTRL   = 5'h00;
   localparam logic [4:0]  REG_WAIT01 = 5'h04;
   localparam logic [4:0]  REG_WAIT23 = 5'h08;
   localparam logic [4:0]  REG_EXTRA  = 5'h0c;
   localparam logic [4:0]  REG_HOLD   = 5'h10;
   localparam logic [4:0]  REG_CYCLE  = 5'h14;
   localparam logic [4:0]  REG_STATUS = 5'h18;

   // Control word fields
   localparam int CTRL_EN_BIT       = 0;
   localparam int CTRL_RST_CLS_BIT  = 1;
   localparam int CTRL_RST_MAN_BIT  = 2;
   localparam int CTRL_LIMIT_LSB    = 4;
   localparam int CTRL_W            = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam int STATUS_PHASE_LSB  = 8;

   // Time slots, in ticks of 0.01 s
   localparam int T_WAIT0   = 0;
   localparam int T_EXTRA_A = 4;
   localparam int T_EXTRA_B = 5;
   localparam int T_INHIBIT = 6;
   localparam int T_LO_DLY  = 7;
   localparam int T_RECLAIM = 8;
   localparam int T_TIMEOUT = 9;
   localparam logic [NUM_T-1:0][TIME_W-1:0] TIME_RST = {
      16'h07d0, 16'h0bb8, 16'h01f4, 16'h03e8, 16'h0000,
      16'h0000, 16'h0190, 16'h012c, 16'h00c8, 16'h0064};

   // Timer slots per bank
   localparam int TM_INHIBIT = 0;
   localparam int TM_DEAD    = 1;
   localparam int TM_TIMEOUT = 2;
   localparam int TM_RECLAIM = 3;
   localparam int TM_LOCKOUT = 4;
   localparam int NUM_TM     = 5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PH_IDLE    = 3'b000,
      PH_DEAD    = 3'b001,
      PH_CLOSING = 3'b010,
      PH_RECLAIM = 3'b011,
      PH_LOCKOUT = 3'b100
   } phase_e;

   typedef struct packed {
      logic cycle_start_input;
      logic inhibit_input;
      logic limit_down_one;
      logic limit_down_two;
      logic limit_down_three;
      logic operator_close_input;
      logic lockout_clear_input;
      logic breaker_closed_status;
      logic breaker_open_status;
      logic extra_wait_a_select;
      logic extra_wait_b_select;
   } breaker_in_s;

   typedef struct packed {
      logic [CNT_W-1:0] attempt_count;
      logic             locked_out;
      logic             cycle_active_flag;
      logic             reclose_disabled;
      logic             reclose_enabled;
      logic             close_command;
   } status_out_s;

   typedef struct packed {
      phase_e           phase;
      logic [CNT_W-1:0] count;
      logic             inhibit_run;
   } bank_s;

   typedef struct packed {
      logic [CTRL_W-1:0]             ctrl;
      logic [NUM_T-1:0][TIME_W-1:0]  t;
   } cfg_s;

endpackage

// ==== reclose_timer.sv ====
// Tick-driven delay timer with level run input and registered expiry
module reclose_timer
   import reclose_pkg::*;
#(
   parameter int W = SUM_W
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         tick,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output logic              done
);

   typedef struct packed {
      logic [W-1:0] count;
      logic         done;
   } tm_s;

   tm_s s_r;
   tm_s s_nxt;

   // Dropping run restarts from zero
   always_comb begin
      s_nxt = s_r;
      if (!run) begin
         s_nxt.count = '0;
      end else if (tick && s_r.count < limit) begin
         s_nxt.count = s_r.count + W'(1);
      end
      s_nxt.done = run && (s_nxt.count >= limit);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;

endmodule // reclose_timer

// ==== breaker_autoreclose_sequencer.sv ====
// Breaker autoreclose sequencer with AXI4-Lite settings store
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
module breaker_autoreclose_sequencer
   import reclose_pkg::*;
#(
   parameter int BANKS    = 2,
   parameter int TICK_DIV = TICK_CYCLES,
   parameter int ADDR_W   = 8
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [ADDR_W-1:0]        awaddr,
   input  wire logic                     awvalid,
   output logic                          awready,
   input  wire logic [31:0]              wdata,
   input  wire logic [3:0]               wstrb,
   input  wire logic                     wvalid,
   output logic                          wready,
   output logic [1:0]                    bresp,
   output logic                          bvalid,
   input  wire logic                     bready,
   input  wire logic [ADDR_W-1:0]        araddr,
   input  wire logic                     arvalid,
   output logic                          arready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   output logic                          rvalid,
   input  wire logic                     rready,
   input  wire breaker_in_s [BANKS-1:0]  bank_in,
   output status_out_s [BANKS-1:0]       bank_out
);

   typedef struct packed {
      breaker_in_s [BANKS-1:0] sync1;
      breaker_in_s [BANKS-1:0] sync2;
      breaker_in_s [BANKS-1:0] prev;
      bank_s [BANKS-1:0]       bank;
      cfg_s [BANKS-1:0]        cfg;
      status_out_s [BANKS-1:0] out;
      logic [DIV_W-1:0]        div;
      logic                    tick;
      logic                    aw_have;
      logic                    w_have;
      logic [ADDR_W-1:0]       waddr;
      logic [31:0]             wdat;
      logic [3:0]              wstb;
      logic                    awready;
      logic                    wready;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    arready;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   logic [BANKS-1:0][NUM_TM-1:0]            tm_run;
   logic [BANKS-1:0][NUM_TM-1:0][SUM_W-1:0] tm_lim;
   logic [BANKS-1:0][NUM_TM-1:0]            tm_done;

   function automatic state_s rst_state();
      state_s r;
      r = '0;
      for (int b = 0; b < BANKS; b++) begin
         r.cfg[b].ctrl = CTRL_RST;
         r.cfg[b].t    = TIME_RST;
         r.out[b].reclose_disabled = 1'b1;
      end
      r.awready = 1'b1;
      r.wready  = 1'b1;
      r.arready = 1'b1;
      return r;
   endfunction

   // Configured limit capped by the limit-down inputs
   function automatic logic [CNT_W-1:0] eff_limit(logic [CTRL_W-1:0] ctrl,
                                                   breaker_in_s      i);
      logic [CNT_W-1:0] l;
      l = CNT_W'(ctrl[CTRL_LIMIT_LSB +: 2]) + 3'h1;
      if (i.limit_down_three && l > 3'h3) l = 3'h3;
      if (i.limit_down_two && l > 3'h2) l = 3'h2;
      if (i.limit_down_one) l = 3'h1;
      return l;
   endfunction

   function automatic logic addr_ok(logic [ADDR_W-1:0] a, logic wr);
      logic [4:0] off;
      off = a[4:0];
      return (int'(a >> BANK_SHIFT) < BANKS) && (off[1:0] == 2'h0)
             && (wr ? off < REG_STATUS : off <= REG_STATUS);
   endfunction

   function automatic logic [31:0] merge(logic [31:0] old,
                                         logic [31:0] nw,
                                         logic [3:0]  strb);
      logic [31:0] m;
      m = old;
      for (int k = 0; k < 4; k++) begin
         if (strb[k]) m[8*k +: 8] = nw[8*k +: 8];
      end
      return m;
   endfunction

   function automatic logic [31:0] time_word(cfg_s c, logic [4:0] off);
      int k;
      k = int'(off[4:2]) - 1;
      return {c.t[2*k+1], c.t[2*k]};
   endfunction

   // Timer requests are taken from registered state
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         breaker_in_s i;
         breaker_in_s p;
         cfg_s        c;
         bank_s       k;
         logic [1:0]  sh;
         i  = s_r.sync2[b];
         p  = s_r.prev[b];
         c  = s_r.cfg[b];
         k  = s_r.bank[b];
         sh = k.count[1:0];
         // A fresh operator close restarts the inhibit time
         tm_run[b][TM_INHIBIT] = k.inhibit_run
            && !(i.operator_close_input && !p.operator_close_input);
         tm_lim[b][TM_INHIBIT] = SUM_W'(c.t[T_INHIBIT]);
         tm_run[b][TM_DEAD] = k.phase == PH_DEAD
            && i.breaker_open_status && k.count < eff_limit(c.ctrl, i);
         tm_lim[b][TM_DEAD] = SUM_W'(c.t[T_WAIT0 + int'(sh)])
            + (i.extra_wait_a_select ? SUM_W'(c.t[T_EXTRA_A]) : '0)
            + (i.extra_wait_b_select ? SUM_W'(c.t[T_EXTRA_B]) : '0);
         tm_run[b][TM_TIMEOUT] = k.phase == PH_DEAD;
         tm_lim[b][TM_TIMEOUT] = SUM_W'(c.t[T_TIMEOUT]);
         tm_run[b][TM_RECLAIM] = k.phase == PH_RECLAIM
            && i.breaker_closed_status;
         tm_lim[b][TM_RECLAIM] = SUM_W'(c.t[T_RECLAIM]);
         tm_run[b][TM_LOCKOUT] = k.phase == PH_LOCKOUT
            && c.ctrl[CTRL_RST_CLS_BIT] && !c.ctrl[CTRL_RST_MAN_BIT]
            && i.breaker_closed_status;
         tm_lim[b][TM_LOCKOUT] = SUM_W'(c.t[T_LO_DLY]);
      end
   end

   always_comb begin
      logic [ADDR_W-1:0] wb;
      logic [4:0]        off;
      logic [31:0]       w;
      logic [ADDR_W-1:0] rb;
      s_nxt = s_r;
      wb    = s_r.waddr >> BANK_SHIFT;
      off   = s_r.waddr[4:0];
      w     = '0;
      rb    = araddr >> BANK_SHIFT;

      // 0.01 s tick
      s_nxt.tick = 1'b0;
      if (s_r.div >= DIV_W'(TICK_DIV - 1)) begin
         s_nxt.div  = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.div = s_r.div + 24'h1;
      end
      s_nxt.sync1 = bank_in;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;

      for (int b = 0; b < BANKS; b++) begin
         breaker_in_s      i;
         breaker_in_s      p;
         cfg_s             c;
         bank_s            k;
         bank_s            nb;
         logic             start_rise;
         logic             close_rise;
         logic             en;
         logic [CNT_W-1:0] lim;
         i  = s_r.sync2[b];
         p  = s_r.prev[b];
         c  = s_r.cfg[b];
         k  = s_r.bank[b];
         nb = k;
         start_rise = i.cycle_start_input && !p.cycle_start_input;
         close_rise = i.operator_close_input && !p.operator_close_input;
         lim = eff_limit(c.ctrl, i);
         en  = c.ctrl[CTRL_EN_BIT] && k.phase != PH_LOCKOUT
               && !i.inhibit_input && !k.inhibit_run;
         if (close_rise) begin
            nb.inhibit_run = 1'b1;
         end else if (tm_done[b][TM_INHIBIT]) begin
            nb.inhibit_run = 1'b0;
         end
         case (k.phase)
            PH_IDLE: begin
               if (en && start_rise && p.breaker_closed_status) begin
                  nb.phase = PH_DEAD;
               end
            end
            PH_DEAD: begin
               if (i.inhibit_input || tm_done[b][TM_TIMEOUT]
                   || k.count >= lim) begin
                  nb.phase = PH_LOCKOUT;
               end else if (tm_done[b][TM_DEAD]) begin
                  nb.phase = PH_CLOSING;
                  nb.count = k.count + 3'h1;
               end
            end
            PH_CLOSING: begin
               if (i.inhibit_input) begin
                  nb.phase = PH_LOCKOUT;
               end else if (i.breaker_closed_status) begin
                  nb.phase = PH_RECLAIM;
               end
            end
            PH_RECLAIM: begin
               if (i.inhibit_input) begin
                  nb.phase = PH_LOCKOUT;
               end else if (en && start_rise && p.breaker_closed_status) begin
                  nb.phase = PH_DEAD;
               end else if (tm_done[b][TM_RECLAIM]) begin
                  nb.phase = PH_IDLE;
                  nb.count = '0;
               end
            end
            PH_LOCKOUT: begin
               if (i.lockout_clear_input
                   || (close_rise && c.ctrl[CTRL_RST_MAN_BIT])
                   || tm_done[b][TM_LOCKOUT]) begin
                  nb.phase = PH_IDLE;
                  nb.count = '0;
               end
            end
            default: begin
               nb.phase = PH_IDLE;
            end
         endcase
         s_nxt.bank[b] = nb;
         en = c.ctrl[CTRL_EN_BIT] && nb.phase != PH_LOCKOUT
              && !i.inhibit_input && !nb.inhibit_run;
         s_nxt.out[b].reclose_enabled   = en;
         s_nxt.out[b].reclose_disabled  = !en;
         s_nxt.out[b].cycle_active_flag = nb.phase == PH_DEAD;
         s_nxt.out[b].locked_out        = nb.phase == PH_LOCKOUT;
         s_nxt.out[b].close_command     = nb.phase == PH_CLOSING;
         s_nxt.out[b].attempt_count     = nb.count;
      end

      // AXI4-Lite write: address and data in either order
      if (s_r.awready && awvalid) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.waddr   = awaddr;
      end
      if (s_r.wready && wvalid) begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdat   = wdata;
         s_nxt.wstb   = wstrb;
      end
      if (s_r.bvalid && bready) s_nxt.bvalid = 1'b0;
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = RESP_SLVERR;
         if (addr_ok(s_r.waddr, 1'b1)) begin
            s_nxt.bresp = RESP_OKAY;
            if (off == REG_CTRL) begin
               w = merge(32'(s_r.cfg[wb].ctrl), s_r.wdat, s_r.wstb);
               s_nxt.cfg[wb].ctrl = w[CTRL_W-1:0];
            end else begin
               w = merge(time_word(s_r.cfg[wb], off), s_r.wdat, s_r.wstb);
               s_nxt.cfg[wb].t[2*(int'(off[4:2])-1)]   = w[15:0];
               s_nxt.cfg[wb].t[2*(int'(off[4:2])-1)+1] = w[31:16];
            end
         end
      end
      s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;

      // AXI4-Lite read
      if (s_r.rvalid && rready) s_nxt.rvalid = 1'b0;
      if (s_r.arready && arvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_SLVERR;
         s_nxt.rdata  = '0;
         if (addr_ok(araddr, 1'b0)) begin
            s_nxt.rresp = RESP_OKAY;
            if (araddr[4:0] == REG_CTRL) begin
               s_nxt.rdata = 32'(s_r.cfg[rb].ctrl);
            end else if (araddr[4:0] == REG_STATUS) begin
               s_nxt.rdata = {20'h0, s_r.bank[rb].inhibit_run,
                              s_r.bank[rb].phase, s_r.out[rb]};
            end else begin
               s_nxt.rdata = time_word(s_r.cfg[rb], araddr[4:0]);
            end
         end
      end
      s_nxt.arready = !s_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= rst_state();
      end else begin
         s_r <= s_nxt;
      end
   end

   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      for (genvar t = 0; t < NUM_TM; t++) begin : g_tm
         reclose_timer #(.W(SUM_W)) u_tm (
            .aclk    (aclk),
            .aresetn (aresetn),
            .tick    (s_r.tick),
            .run     (tm_run[b][t]),
            .limit   (tm_lim[b][t]),
            .done    (tm_done[b][t])
         );
      end
   end

   assign awready  = s_r.awready;
   assign wready   = s_r.wready;
   assign bvalid   = s_r.bvalid;
   assign bresp    = s_r.bresp;
   assign arready  = s_r.arready;
   assign rvalid   = s_r.rvalid;
   assign rdata    = s_r.rdata;
   assign rresp    = s_r.rresp;
   assign bank_out = s_r.out;

   // Checks on bank 0 and on the write response
   phase_e      ph0;
   breaker_in_s i0;
   logic        cls_rise0;
   assign ph0       = s_r.bank[0].phase;
   assign i0        = s_r.sync2[0];
   assign cls_rise0 = i0.operator_close_input
                      && !s_r.prev[0].operator_close_input;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_start_closed: assert property (
      (ph0 == PH_DEAD && $past(ph0) == PH_IDLE)
      |-> $past(s_r.prev[0].breaker_closed_status))
      else $error("cycle started with breaker not closed");
   // Output was built from the settings of the cycle before
   a_enable_terms: assert property (
      s_r.out[0].reclose_enabled |-> $past(s_r.cfg[0].ctrl[CTRL_EN_BIT])
      && ph0 != PH_LOCKOUT && !s_r.bank[0].inhibit_run)
      else $error("enabled while a disabling term holds");
   a_active_latched: assert property (
      (ph0 == PH_DEAD && !i0.inhibit_input && !tm_done[0][TM_TIMEOUT]
       && !tm_done[0][TM_DEAD]
       && s_r.bank[0].count < eff_limit(s_r.cfg[0].ctrl, i0))
      |=> s_r.out[0].cycle_active_flag)
      else $error("cycle active flag dropped early");
   a_close_cause: assert property (
      $rose(s_r.out[0].close_command) |-> $past(tm_done[0][TM_DEAD]))
      else $error("close issued without dead time expiry");
   a_close_held: assert property (
      (ph0 == PH_CLOSING && !i0.breaker_closed_status
       && !i0.inhibit_input)
      |=> s_r.out[0].close_command && ph0 == PH_CLOSING)
      else $error("close command not held");
   a_block_lock: assert property (
      (ph0 inside {PH_DEAD, PH_CLOSING, PH_RECLAIM} && i0.inhibit_input)
      |=> ph0 == PH_LOCKOUT && s_r.out[0].locked_out)
      else $error("block input did not lock out");
   a_limit_lock: assert property (
      (ph0 == PH_DEAD
       && s_r.bank[0].count >= eff_limit(s_r.cfg[0].ctrl, i0))
      |=> ph0 == PH_LOCKOUT)
      else $error("attempt limit did not lock out");
   a_timeout_lock: assert property (
      (ph0 == PH_DEAD && tm_done[0][TM_TIMEOUT]) |=> ph0 == PH_LOCKOUT)
      else $error("cycle timeout did not lock out");
   a_lock_hold: assert property (
      (ph0 == PH_LOCKOUT && !i0.lockout_clear_input && !cls_rise0
       && !tm_done[0][TM_LOCKOUT]) |=> ph0 == PH_LOCKOUT)
      else $error("lockout released without a reset");
   a_inhibit_start: assert property (
      cls_rise0 |=> !s_r.out[0].reclose_enabled)
      else $error("operator close did not disable");
   a_count_step: assert property (
      (ph0 == PH_CLOSING && $past(ph0) == PH_DEAD)
      |-> s_r.bank[0].count == $past(s_r.bank[0].count) + 3'h1)
      else $error("attempt count did not step");
   a_write_resp: assert property (
      (s_r.aw_have && s_r.w_have && !s_r.bvalid) |=> s_r.bvalid)
      else $error("write response missing");

   c_close: cover property (ph0 == PH_DEAD ##1 ph0 == PH_CLOSING);
   c_reclaim: cover property (ph0 == PH_RECLAIM ##1 ph0 == PH_IDLE);
   c_lockout: cover property (ph0 == PH_DEAD ##1 ph0 == PH_LOCKOUT);
   c_unlock: cover property (ph0 == PH_LOCKOUT ##1 ph0 == PH_IDLE);

endmodule // breaker_autoreclose_sequencer

// ==== breaker_model.sv ====
// Breaker and trip circuit partner model for the sequencer
module breaker_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic trip,
   input  wire logic close_req,
   output logic      closed_status,
   output logic      open_status
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] dly_r;
   assign open_status = ~closed_status;
   // Contacts move seven cycles after a held command
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         closed_status <= 1'b1;
         dly_r         <= 4'h0;
      end else if (closed_status ? trip : close_req) begin
         dly_r <= dly_r + 4'h1;
         if (dly_r == 4'h6) begin
            closed_status <= ~closed_status;
            dly_r         <= 4'h0;
         end
      end else begin
         dly_r <= 4'h0;
      end
   end
endmodule // breaker_model

// ==== breaker_autoreclose_sequencer_tb.sv ====
// Self-checking bench for the breaker autoreclose sequencer
`define CHK(nm, e, s) \
   begin \
      tests_run++; \
      if ((s) !== (e)) begin \
         n_errors++; \
         $display("mismatch %s expected %h seen %h", nm, e, s); \
      end \
   end
module breaker_autoreclose_sequencer_tb
   import reclose_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              aclk, aresetn, brk_cl, brk_op;
   logic [7:0]        awaddr, araddr, st;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [31:0]       wdata, rdata;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp;
   breaker_in_s       bi0, bi1;
   breaker_in_s [1:0] bank_in;
   status_out_s [1:0] bank_out;
   int                n_errors, tests_run, exp_count;
   always_comb begin
      bank_in = {bi1, bi0};
      bank_in[0].breaker_closed_status = brk_cl;
      bank_in[0].breaker_open_status = brk_op;
   end
   assign st = bank_out[0];
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   breaker_autoreclose_sequencer #(.TICK_DIV(4)) dut (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .bank_in, .bank_out);
   breaker_model brk (.aclk, .aresetn, .trip(bi0.cycle_start_input),
      .close_req(st[0] | bi0.operator_close_input),
      .closed_status(brk_cl), .open_status(brk_op));
   task summarize;
      $display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      {awvalid, wvalid, bready} <= 3'h7;
      for (int k = 0; k < 50; k++) begin
         @(negedge aclk);
         {ta, tw, tb, r} = {awready, wready, bvalid, bresp};
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) begin
            bready <= 1'b0;
            `CHK("bresp", er, r)
            return;
         end
      end
      n_errors++;
      summarize();
   endtask
   task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (int k = 0; k < 50; k++) begin
         @(negedge aclk);
         {ta, tr, d, r} = {arready, rvalid, rdata, rresp};
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) begin
            rready <= 1'b0;
            `CHK("rdata", ed, d)
            `CHK("rresp", er, r)
            return;
         end
      end
      n_errors++;
      summarize();
   endtask
   task wait_bit(input int b, input logic v);
      int k;
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (st[b] !== v && k < 3000);
      if (st[b] !== v) begin
         n_errors++;
         $display("mismatch status bit %0d expected %b seen %b", b, v, st[b]);
         summarize();
      end
   endtask
   task drive(input int b, input logic v);
      @(posedge aclk);
      bi0[b] <= v;
      bi1 <= 11'($urandom);
   endtask
   // Trip once; model predicts reclose or lockout from its own count
   task shot(input int lim);
      logic lk;
      lk = exp_count >= lim;
      drive(10, 1'b1);
      wait_bit(lk ? 4 : 3, 1'b1);
      repeat (8) @(posedge aclk);
      drive(10, 1'b0);
      if (lk) begin
         `CHK("enabled", 1'b0, st[1])
      end else begin
         wait_bit(0, 1'b1);
         exp_count++;
         `CHK("in progress", 1'b0, st[3])
         wait_bit(0, 1'b0);
      end
      `CHK("count", 3'(exp_count), st[7:5])
      $display("test shot done");
   endtask
   task unlock;
      drive(4, 1'b1);
      wait_bit(4, 1'b0);
      drive(4, 1'b0);
      exp_count = 0;
      `CHK("count", 3'(exp_count), st[7:5])
      drive(5, 1'b1);
      repeat (8) @(posedge aclk);
      drive(5, 1'b0);
      wait_bit(1, 1'b0);
      wait_bit(1, 1'b1);
      $display("test unlock done");
   endtask
   initial begin
      {n_errors, tests_run, exp_count} = '0;
      {awaddr, araddr, wdata, wstrb, bi0, bi1} = '0;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      void'($urandom(91134));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHK("status", 8'h04, st)
      axr(8'h00, 32'h0, RESP_OKAY);
      axr(8'h04, 32'h00c8_0064, RESP_OKAY);
      axr(8'h10, 32'h01f4_03e8, RESP_OKAY);
      axr(8'h40, 32'h0, RESP_SLVERR);
      axw(8'h18, 32'h0, RESP_SLVERR);
      axw(8'h04, 32'h0003_0002, RESP_OKAY);
      axw(8'h0c, 32'h0040_0040, RESP_OKAY);
      axw(8'h10, 32'h0002_0010, RESP_OKAY);
      axw(8'h14, 32'h0100_0040, RESP_OKAY);
      axw(8'h00, 32'h0000_0011, RESP_OKAY);
      wait_bit(1, 1'b1);
      axr(8'h04, 32'h0003_0002, RESP_OKAY);
      axr(8'h18, 32'h0000_0002, RESP_OKAY);
      $display("test settings done");
      repeat (3) shot(2);
      unlock;
      drive(1, 1'b1);
      drive(0, 1'b1);
      drive(10, 1'b1);
      wait_bit(3, 1'b1);
      repeat (100) @(posedge aclk);
      `CHK("extended wait", 2'h2, {st[3], st[0]})
      drive(9, 1'b1);
      wait_bit(4, 1'b1);
      `CHK("close", 3'h0, {st[0], st[6:5]})
      for (int b = 10; b >= 0; b--) drive(b, 1'b0);
      $display("test block done");
      unlock;
      drive(8, 1'b1);
      repeat (2) shot(1);
      drive(8, 1'b0);
      unlock;
      axw(8'h00, 32'h0000_0017, RESP_OKAY);
      shot(2);
      wait_bit(5, 1'b0);
      exp_count = 0;
      `CHK("count", 3'(exp_count), st[7:5])
      // Short trip leaves the breaker closed, so the cycle times out
      drive(10, 1'b1);
      drive(10, 1'b0);
      wait_bit(4, 1'b1);
      repeat (20) @(posedge aclk);
      `CHK("held lockout", 1'b1, st[4])
      drive(5, 1'b1);
      wait_bit(4, 1'b0);
      drive(5, 1'b0);
      `CHK("enabled", 1'b0, st[1])
      `CHK("bank1", 8'h04, bank_out[1])
      $display("test timeout done");
      summarize();
   end
endmodule // breaker_autoreclose_sequencer_tb
